// [verilog/scie_ctrl.sv]
// scie_ctrl: control register, interrupt request gating, transmit start
// and tx fifo low flag of a fifo-buffered serial unit, behind an apb slave.
// assumes fifo counts, shifter busy and receive flags come from logic on
// the same clock, so they are read without synchronisers.
//
// Notes on behaviour
// - power-on reset clears serial control to zero
// - control is 16 bits, only bits 7, 6, 5 and 3 writable
// - upper eight control bits read as zero
// - bit 7 gates the tx empty request
// - queued words move to shifter one by one
// - tx low flag sets when count below trigger
// - low flag with enable raises tx empty request
// - clearing tx irq enable withdraws tx request
// - bit 6 gates rx full on full/ready
// - rx enable raises fault request on fault
// - rx enable raises break on break/overrun
// - rx full clears by flag clear or disable
// - fault/break clear by flag or both enables
// - fault enable keeps fault/break on without rx
// - bit 5 switches transmitter on or off
// - transmission starts only once fifo holds data
//
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/1ns

module scie_ctrl #(
  parameter int CW = 5
) (
  input  wire logic          clock,
  input  wire logic          rst,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic [CW-1:0] tx_fifo_count,
  input  wire logic [CW-1:0] tx_trigger,
  input  wire logic          tx_shift_busy,
  input  wire logic          rx_fifo_full_flag,
  input  wire logic          rx_data_ready_flag,
  input  wire logic          rx_fault_flag,
  input  wire logic          line_break_flag,
  input  wire logic          overrun_flag,
  output logic               tx_enable,
  output logic               tx_load,
  output logic               tx_fifo_low_flag,
  output logic               tx_fifo_empty_irq,
  output logic               rx_full_irq,
  output logic               rx_fault_irq,
  output logic               line_break_irq,
  output logic               irq
);

  // the fifo counts are compared as plain unsigned words of this width
  if (CW < 1 || CW > 16) begin : g_cw_check
    $error("scie_ctrl: CW must be 1..16");
  end

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic [scie_pkg::CTRL_W-1:0] ctrl;
  logic [3:0]  status;
  logic [3:0]  mask;
  logic        low_seen;
  logic [3:0]  req_prev;

  // ----------------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------------
  wire setup     = psel & ~penable;
  wire access    = psel & penable;
  wire hit_ctrl  = (paddr == scie_pkg::OFF_CTRL);
  wire hit_flags = (paddr == scie_pkg::OFF_FLAGS);
  wire hit_stat  = (paddr == scie_pkg::OFF_STATUS);
  wire hit_mask  = (paddr == scie_pkg::OFF_MASK);
  wire mapped    = hit_ctrl | hit_flags | hit_stat | hit_mask;
  wire wr_ctrl   = access & pwrite & hit_ctrl;
  wire wr_flags  = access & pwrite & hit_flags;
  wire wr_mask   = access & pwrite & hit_mask;
  wire rd_stat   = access & ~pwrite & hit_stat;
  wire rd_flags  = access & ~pwrite & hit_flags;

  // zero wait states: the access phase always completes at its first edge
  assign pready = 1'b1;

  wire [5:0] flag_view = {overrun_flag, line_break_flag, rx_fault_flag,
                          rx_data_ready_flag, rx_fifo_full_flag, tx_fifo_low_flag};

  // read data is captured in setup so prdata comes from a flop; the
  // read-clear below then clears only what software actually saw
  wire [31:0] rd_mux =
    hit_ctrl  ? {16'h0000, 8'h00, ctrl[7:0]} :
    hit_flags ? {26'h0, flag_view} :
    hit_stat  ? {28'h0, status} :
    hit_mask  ? {28'h0, mask} : 32'h0;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata  <= pwrite ? 32'h0 : rd_mux;
      pslverr <= ~mapped;
    end
  end

  // ----------------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------------
  wire [15:0] next_ctrl = pwdata[15:0] & scie_pkg::CTRL_WMASK;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl <= scie_pkg::CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl <= next_ctrl;
    end
  end

  wire tie_bit   = ctrl[scie_pkg::BIT_TX_FIFO_IRQ_EN];
  wire rie_bit   = ctrl[scie_pkg::BIT_RX_IRQ_EN];
  wire fault_en  = ctrl[scie_pkg::BIT_RX_FAULT_EN];
  assign tx_enable = ctrl[scie_pkg::BIT_TX_ENABLE];

  // ----------------------------------------------------------------------
  // tx fifo low flag: read as 1, then write 0; a low fifo re-sets it
  // ----------------------------------------------------------------------
  wire low_now  = (tx_fifo_count < tx_trigger);
  wire low_clr  = wr_flags & ~pwdata[scie_pkg::FLG_TX_LOW] & low_seen;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tx_fifo_low_flag <= 1'b0;
      low_seen         <= 1'b0;
    end else begin
      tx_fifo_low_flag <= low_now | (tx_fifo_low_flag & ~low_clr);
      if (rd_flags && prdata[scie_pkg::FLG_TX_LOW]) begin
        low_seen <= 1'b1;
      end else if (wr_flags) begin
        low_seen <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // transmit start: one load per word, only with data and enable
  // ----------------------------------------------------------------------
  wire have_word = (tx_fifo_count != '0);
  wire next_load = tx_enable & have_word & ~tx_shift_busy & ~tx_load;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tx_load <= 1'b0;
    end else begin
      tx_load <= next_load;
    end
  end

  // ----------------------------------------------------------------------
  // interrupt request gating
  // ----------------------------------------------------------------------
  // fault enable only matters while the rx enable is 0, hence the or
  wire fault_gate = rie_bit | fault_en;
  wire next_txi = tie_bit & tx_fifo_low_flag;
  wire next_rxi = rie_bit & (rx_fifo_full_flag | rx_data_ready_flag);
  wire next_eri = fault_gate & rx_fault_flag;
  wire next_bri = fault_gate & (line_break_flag | overrun_flag);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tx_fifo_empty_irq <= 1'b0;
      rx_full_irq       <= 1'b0;
      rx_fault_irq      <= 1'b0;
      line_break_irq    <= 1'b0;
    end else begin
      tx_fifo_empty_irq <= next_txi;
      rx_full_irq       <= next_rxi;
      rx_fault_irq      <= next_eri;
      line_break_irq    <= next_bri;
    end
  end

  // ----------------------------------------------------------------------
  // sticky status, mask and interrupt line
  // ----------------------------------------------------------------------
  wire [3:0] req_now = {line_break_irq, rx_fault_irq, rx_full_irq, tx_fifo_empty_irq};
  wire [3:0] rise    = req_now & ~req_prev;
  // a new rise in the clearing cycle wins over the clear
  wire [3:0] rd_clr  = rd_stat ? prdata[3:0] : 4'h0;
  wire [3:0] next_status = rise | (status & ~rd_clr);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      status   <= scie_pkg::STATUS_RESET;
      mask     <= scie_pkg::MASK_RESET;
      req_prev <= 4'h0;
    end else begin
      status   <= next_status;
      req_prev <= req_now;
      if (wr_mask) begin
        mask <= pwdata[3:0];
      end
    end
  end

  assign irq = |(status & mask);

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // properties below use the default clock and hold off during reset
  // tracks the first control write so the reset value is checked up to it
  logic ctrl_written;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl_written <= 1'b0;
    end else if (wr_ctrl) begin
      ctrl_written <= 1'b1;
    end
  end

  property p_ctrl_reset_zero;
    !ctrl_written |-> (ctrl == scie_pkg::CTRL_RESET);
  endproperty
  a_ctrl_reset_zero: assert property (p_ctrl_reset_zero)
    else $error("control not zero before write");

  property p_ctrl_write;
    wr_ctrl |=> (ctrl == ($past(pwdata[15:0]) & scie_pkg::CTRL_WMASK));
  endproperty
  a_ctrl_write: assert property (p_ctrl_write)
    else $error("control write not stored");

  property p_ctrl_read_upper;
    (setup && !pwrite && hit_ctrl) |=>
      (prdata[31:8] == 24'h000000) && (prdata[7:0] == ctrl[7:0]);
  endproperty
  a_ctrl_read_upper: assert property (p_ctrl_read_upper)
    else $error("control readback wrong");

  property p_low_set;
    low_now |=> tx_fifo_low_flag;
  endproperty
  a_low_set: assert property (p_low_set)
    else $error("low flag not set");

  // judged on the enable of the cycle before, as the request is registered
  property p_txi_set;
    (tie_bit && tx_fifo_low_flag) |=> tx_fifo_empty_irq;
  endproperty
  a_txi_set: assert property (p_txi_set)
    else $error("tx request missing");

  property p_low_clear;
    (low_clr && !low_now) |=> !tx_fifo_low_flag;
  endproperty
  a_low_clear: assert property (p_low_clear)
    else $error("low flag not cleared");

  property p_txi_gate;
    !tie_bit |=> !tx_fifo_empty_irq;
  endproperty
  a_txi_gate: assert property (p_txi_gate)
    else $error("tx request not gated");

  property p_rxi;
    (rie_bit && (rx_fifo_full_flag || rx_data_ready_flag)) |=> rx_full_irq;
  endproperty
  a_rxi: assert property (p_rxi)
    else $error("rx full request missing");

  property p_rxi_off;
    !rie_bit |=> !rx_full_irq;
  endproperty
  a_rxi_off: assert property (p_rxi_off)
    else $error("rx full request not withdrawn");

  property p_rx_fault;
    (rie_bit && rx_fault_flag) |=> rx_fault_irq;
  endproperty
  a_rx_fault: assert property (p_rx_fault)
    else $error("fault request missing with rx enable");

  property p_fault_on;
    (fault_en && !rie_bit && rx_fault_flag) |=> rx_fault_irq;
  endproperty
  a_fault_on: assert property (p_fault_on)
    else $error("fault request missing");

  property p_fault_off;
    (!rie_bit && !fault_en) |=> (!rx_fault_irq && !line_break_irq);
  endproperty
  a_fault_off: assert property (p_fault_off)
    else $error("fault or break not withdrawn");

  property p_break;
    (rie_bit && (line_break_flag || overrun_flag)) |=> line_break_irq;
  endproperty
  a_break: assert property (p_break)
    else $error("break request missing");

  property p_load_cause;
    tx_load |-> $past(tx_enable) && $past(tx_fifo_count) != '0 && !$past(tx_shift_busy);
  endproperty
  a_load_cause: assert property (p_load_cause)
    else $error("load without enable or data");

  // the shifter side needs one cycle to take the word before the next load
  property p_load_gap;
    tx_load |=> !tx_load;
  endproperty
  a_load_gap: assert property (p_load_gap)
    else $error("loads back to back");

  property p_status_set;
    $rose(rx_fault_irq) |=> status[scie_pkg::EVT_RX_FAULT];
  endproperty
  a_status_set: assert property (p_status_set)
    else $error("status not set on request rise");

  // a rise in the clearing cycle is left out: the set wins there
  property p_read_clear;
    (rd_stat && (rise == 4'h0)) |=> ((status & $past(prdata[3:0])) == 4'h0);
  endproperty
  a_read_clear: assert property (p_read_clear)
    else $error("status not cleared by read");

  property p_irq_line;
    ($rose(rx_full_irq) && mask[scie_pkg::EVT_RX_FULL] && !wr_mask) |=> irq;
  endproperty
  a_irq_line: assert property (p_irq_line)
    else $error("interrupt line low");

  c_load: cover property (tx_load ##1 !tx_load);
  c_irq: cover property ($rose(irq));
  c_low_clear: cover property (tx_fifo_low_flag ##1 !tx_fifo_low_flag);
  c_stat_clear: cover property (rd_stat && status != 4'h0);
  c_fault_only: cover property (fault_en && !rie_bit && rx_fault_irq);

endmodule

// [verilog/scie_pkg.sv]
// scie_pkg: register map, field positions and reset values of the serial
// control and interrupt-enable block.
// assumes a 32-bit apb slave whose registers each occupy one aligned word.
package scie_pkg;

  // ----------------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_FLAGS  = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_MASK   = 8'h0c;

  // ----------------------------------------------------------------------
  // serial_control fields
  // ----------------------------------------------------------------------
  localparam int CTRL_W             = 16;
  localparam int BIT_TX_FIFO_IRQ_EN = 7;
  localparam int BIT_RX_IRQ_EN      = 6;
  localparam int BIT_TX_ENABLE      = 5;
  localparam int BIT_RX_FAULT_EN    = 3;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] CTRL_WMASK = 16'h00e8;

  // ----------------------------------------------------------------------
  // flags register fields (tx low flag writable, rest read-only views)
  // ----------------------------------------------------------------------
  localparam int FLG_TX_LOW     = 0;
  localparam int FLG_RX_FULL    = 1;
  localparam int FLG_RX_READY   = 2;
  localparam int FLG_RX_FAULT   = 3;
  localparam int FLG_LINE_BREAK = 4;
  localparam int FLG_OVERRUN    = 5;

  // ----------------------------------------------------------------------
  // interrupt status and mask layout
  // ----------------------------------------------------------------------
  localparam int IRQ_N        = 4;
  localparam int EVT_TX_EMPTY = 0;
  localparam int EVT_RX_FULL  = 1;
  localparam int EVT_RX_FAULT = 2;
  localparam int EVT_BREAK    = 3;
  localparam logic [3:0] STATUS_RESET = 4'h0;
  localparam logic [3:0] MASK_RESET   = 4'h0;

endpackage

// [dv/tb.sv]
// tb: self-checking bench for the serial control and irq-enable block.
// assumes a zero-wait apb slave and fifo/receive inputs on the same clock.
`timescale 1ns/1ns

module tb;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        tx_shift_busy = 1'b0;
  logic [4:0]  fill = 5'h08;
  logic [4:0]  tx_trigger = 5'h04;
  logic [4:0]  rxf = 5'h00;
  logic        tx_enable;
  logic        tx_load;
  logic        tx_fifo_low_flag;
  logic [3:0]  req;
  logic        irq;
  logic [34:0] exp_q[$];
  logic [34:0] ev;
  logic [31:0] d;
  logic [3:0]  e;
  logic        rx_irq_en;
  logic        rx_fault_irq_en;
  logic [7:0]  cvals[4] = '{8'h00, 8'h40, 8'h08, 8'h48};
  int          fail_count = 0;
  int          comparisons = 0;
  int          seed = 17256;
  int          loads = 0;
  wire  [4:0]  tx_fifo_count = fill - 5'(loads);

  scie_ctrl u_scie_ctrl (
    .clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_fifo_count(tx_fifo_count), .tx_trigger(tx_trigger), .tx_shift_busy(tx_shift_busy),
    .rx_fifo_full_flag(rxf[0]), .rx_data_ready_flag(rxf[1]), .rx_fault_flag(rxf[2]),
    .line_break_flag(rxf[3]), .overrun_flag(rxf[4]), .tx_enable(tx_enable),
    .tx_load(tx_load), .tx_fifo_low_flag(tx_fifo_low_flag), .tx_fifo_empty_irq(req[0]),
    .rx_full_irq(req[1]), .rx_fault_irq(req[2]), .line_break_irq(req[3]), .irq(irq));

  always #25 clock = ~clock;

  task automatic give_verdict;
    $display("counts: %0d comparisons, %0d mismatches", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // ----------------------------------------------------------------------
  // apb master; kind 0 write, 1 checked read, 2 read with data ignored
  // ----------------------------------------------------------------------
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] dat,
                     input logic [1:0] k, input logic [31:0] x);
    @(posedge clock);
    exp_q.push_back({k, a > 8'h0c, x});
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= dat;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] dat);
    apb(1'b1, a, dat, 2'd0, 32'h0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [1:0] k = 2'd1);
    apb(1'b0, a, 32'h0, k, x);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // the answer is taken at the edge where pready is seen with the access phase
  always @(posedge clock) begin
    if (psel && penable && pready === 1'b1) begin
      ev = exp_q.pop_front();
      chk(32'(pslverr), 32'(ev[32]));
      if (ev[34:33] == 2'd1) chk(prdata, ev[31:0]);
    end
  end

  // shifter side: each load takes one word out of the fifo by the next cycle
  always @(posedge clock) begin
    if (tx_load === 1'b1) begin
      loads <= loads + 1;
    end
  end

  initial begin
    #1000000;
    fail_count++;
    give_verdict();
  end

  initial begin
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    rd(8'h00, 32'h0);
    rd(8'h0c, 32'h0);
    rd(8'h08, 32'h0);
    chk(32'(req), 32'h0);
    $display("test reset done");
    // busy keeps the shifter from draining while random writes set tx_enable
    @(posedge clock);
    tx_shift_busy <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      d = $random(seed);
      wr(8'h00, d);
      rd(8'h00, d & {16'h0, scie_pkg::CTRL_WMASK});
    end
    wr(8'h00, 32'h0);
    wr(8'h10, 32'hffffffff);
    rd(8'h10, 32'h0);
    rd(8'h00, 32'h0);
    $display("test regs done");
    @(posedge clock);
    fill <= 5'h04;
    tick(2);
    chk(32'(tx_fifo_low_flag), 32'h0);
    @(posedge clock);
    tx_trigger <= 5'h05;
    tick(2);
    chk(32'(tx_fifo_low_flag), 32'h1);
    chk(32'(req[0]), 32'h0);
    wr(8'h00, 32'h80);
    tick(2);
    chk(32'(req[0]), 32'h1);
    wr(8'h00, 32'h0);
    tick(2);
    chk(32'(req[0]), 32'h0);
    wr(8'h00, 32'h80);
    @(posedge clock);
    fill <= 5'h05;
    rd(8'h04, 32'h1);
    wr(8'h04, 32'h0);
    tick(2);
    chk(32'(tx_fifo_low_flag), 32'h0);
    chk(32'(req[0]), 32'h0);
    $display("test tx irq done");
    for (int c = 0; c < 4; c++) begin
      wr(8'h00, {24'h0, cvals[c]});
      rx_irq_en = cvals[c][6];
      rx_fault_irq_en = cvals[c][3];
      for (int s = 0; s < 5; s++) begin
        @(posedge clock);
        rxf <= 5'h01 << s;
        tick(2);
        e = {(rx_irq_en || rx_fault_irq_en) && s > 2, (rx_irq_en || rx_fault_irq_en) && s == 2, rx_irq_en && s < 2, 1'b0};
        chk(32'(req), 32'(e));
        rd(8'h04, {26'h0, 5'h01 << s, 1'b0});
        @(posedge clock);
        rxf <= 5'h00;
        tick(2);
        chk(32'(req), 32'h0);
      end
    end
    @(posedge clock);
    rxf <= 5'h05;
    wr(8'h00, 32'h48);
    tick(2);
    chk(32'(req), 32'h6);
    wr(8'h00, 32'h08);
    tick(2);
    chk(32'(req), 32'h4);
    wr(8'h00, 32'h0);
    tick(2);
    chk(32'(req), 32'h0);
    $display("test rx irq done");
    rd(8'h08, 32'h0, 2'd2);
    rd(8'h08, 32'h0);
    wr(8'h0c, 32'h0);
    wr(8'h00, 32'h40);
    tick(3);
    chk(32'(irq), 32'h0);
    wr(8'h0c, 32'h2);
    rd(8'h0c, 32'h2);
    tick(1);
    chk(32'(irq), 32'h1);
    rd(8'h08, 32'h6);
    tick(1);
    chk(32'(irq), 32'h0);
    wr(8'h00, 32'h0);
    tick(2);
    wr(8'h00, 32'h40);
    tick(2);
    chk(32'(irq), 32'h1);
    rd(8'h08, 32'h6);
    @(posedge clock);
    rxf <= 5'h00;
    wr(8'h00, 32'h0);
    $display("test status done");
    @(posedge clock);
    tx_shift_busy <= 1'b0;
    fill <= 5'h03;
    tick(6);
    chk(32'(loads), 32'h0);
    @(posedge clock);
    fill <= 5'h00;
    wr(8'h00, 32'h20);
    tick(6);
    chk(32'(loads), 32'h0);
    @(posedge clock);
    fill <= 5'h03;
    tick(20);
    chk(32'(loads), 32'h3);
    chk(32'(tx_enable), 32'h1);
    wr(8'h00, 32'h0);
    tick(2);
    chk(32'(tx_enable), 32'h0);
    $display("test tx start done");
    give_verdict();
  end
endmodule
